// >>> pkg/dal_pkg.sv
// Package for the debug access lock: reset values, comparator counts, states.
// Assumes one system clock at 250 MHz and an asynchronous active-high reset.
package dal_pkg;
	// ==========================================================
	// Comparator counts offered to the debug host
	localparam int unsigned DAL_NUM_BKPT = 4;
	localparam int unsigned DAL_NUM_WPT = 2;
	// ==========================================================
	// Reset values
	localparam logic DAL_DBG_EN_RST = 1'b1;
	localparam logic DAL_SEC_RST = 1'b0;
	// ==========================================================
	// Access states
	typedef enum logic [1:0] {
		DAL_ST_EVAL,
		DAL_ST_OPEN,
		DAL_ST_CLOSED,
		DAL_ST_SECURE
	} dal_state_t;
endpackage

// >>> verilog/dal_debug_access_lock.sv
// Debug access lock for the two-wire serial debug port.
// Assumes protection and security levels come from flash on the same clock,
// and the serial link request pin arrives asynchronously.
//
// Operation
// - Debug enabled after reset by default
// - Only firmware may disable debug
// - Re-enable only after erase and unprotect
// - Maximum security permanently blocks all access
// - All debug through serial wire only
// - Four breakpoint, two watchpoint comparators
`timescale 1ns/10ps
`default_nettype none
module dal_debug_access_lock #(
	parameter int unsigned NUM_BKPT = dal_pkg::DAL_NUM_BKPT,
	parameter int unsigned NUM_WPT = dal_pkg::DAL_NUM_WPT
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic fw_dbg_disable,
	input wire logic fw_dbg_enable,
	input wire logic flash_protected,
	input wire logic device_erased,
	input wire logic sec_max,
	input wire logic swd_req_pin,
	output logic swd_grant,
	output logic dbg_enable,
	output logic test_enable,
	output logic sec_locked,
	output logic [2:0] bkpt_count,
	output logic [1:0] wpt_count,
	output var dal_pkg::dal_state_t state
);
	import dal_pkg::*;

	// ==========================================================
	// Pin synchroniser, three stages, second and third must agree
	logic [2:0] req_sync_r;
	logic [2:0] req_sync_nxt;
	logic req_r;
	logic req_nxt;
	always_comb begin
		req_sync_nxt = {req_sync_r[1:0], swd_req_pin};
		req_nxt = req_r;
		if (req_sync_r[1] == req_sync_r[2]) begin
			req_nxt = req_sync_r[2];
		end
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			req_sync_r <= 3'h0;
			req_r <= 1'b0;
		end else begin
			req_sync_r <= req_sync_nxt;
			req_r <= req_nxt;
		end
	end

	// ==========================================================
	// Access state machine
	dal_state_t state_r;
	dal_state_t state_nxt;
	logic en_r;
	logic en_nxt;
	logic sec_r;
	logic sec_nxt;
	always_comb begin
		state_nxt = state_r;
		en_nxt = en_r;
		sec_nxt = sec_r;
		case (state_r)
			DAL_ST_EVAL: begin
				// Port stays gated this cycle while the sampled states settle
				// Security memory wins even after the level input drops
				if (sec_max || sec_r) begin
					state_nxt = DAL_ST_SECURE;
					sec_nxt = 1'b1;
					en_nxt = 1'b0;
				end else if (en_r) begin
					state_nxt = DAL_ST_OPEN;
				end else begin
					state_nxt = DAL_ST_CLOSED;
				end
			end
			DAL_ST_OPEN: begin
				if (sec_max) begin
					state_nxt = DAL_ST_SECURE;
					sec_nxt = 1'b1;
					en_nxt = 1'b0;
				end else if (fw_dbg_disable) begin
					// Host requests have no path here, only firmware
					state_nxt = DAL_ST_CLOSED;
					en_nxt = 1'b0;
				end
			end
			DAL_ST_CLOSED: begin
				if (sec_max) begin
					state_nxt = DAL_ST_SECURE;
					sec_nxt = 1'b1;
				end else if (fw_dbg_enable && device_erased &&
					!flash_protected) begin
					state_nxt = DAL_ST_OPEN;
					en_nxt = 1'b1;
				end
			end
			DAL_ST_SECURE: begin
				// No exit: the lock outlives every later host action
				state_nxt = DAL_ST_SECURE;
			end
			default: begin
				state_nxt = DAL_ST_SECURE;
			end
		endcase
	end

	// Enable memory survives reset; reset only restarts evaluation.
	// A real part keeps it in flash, here in a flop initialised only by power-up.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_r <= DAL_ST_EVAL;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Declaration value stands for power-up; rst never touches it
	logic por_done_r = 1'b0;
	always_ff @(posedge clk) begin
		if (!por_done_r) begin
			en_r <= DAL_DBG_EN_RST;
			sec_r <= DAL_SEC_RST;
			por_done_r <= 1'b1;
		end else begin
			en_r <= en_nxt;
			sec_r <= sec_nxt;
		end
	end

	// ==========================================================
	// Outputs
	always_comb begin
		// Serial link is the one and only debug path
		swd_grant = req_r && (state_r == DAL_ST_OPEN);
		dbg_enable = (state_r == DAL_ST_OPEN);
		test_enable = (state_r == DAL_ST_OPEN);
		sec_locked = (state_r == DAL_ST_SECURE);
		state = state_r;
		bkpt_count = 3'(NUM_BKPT);
		wpt_count = 2'(NUM_WPT);
	end

	// ==========================================================
	// Checks
	AST_NO_GRANT_EVAL: assert property (
		@(posedge clk) disable iff (rst)
		state_r == DAL_ST_EVAL |-> !swd_grant
	) else $error("Grant during evaluation");
	AST_EVAL_ONE_CYCLE: assert property (
		@(posedge clk) disable iff (rst)
		state_r == DAL_ST_EVAL |=> state_r != DAL_ST_EVAL
	) else $error("Evaluation longer than one cycle");
	AST_SECURE_STICKS: assert property (
		@(posedge clk) disable iff (rst)
		state_r == DAL_ST_SECURE |=> state_r == DAL_ST_SECURE
	) else $error("Secure state left");
	AST_SECURE_BLOCKS: assert property (
		@(posedge clk) disable iff (rst)
		sec_locked |-> !swd_grant && !dbg_enable && !test_enable
	) else $error("Access while secure");
	AST_SEC_ENTRY: assert property (
		@(posedge clk) disable iff (rst)
		sec_max |=> state_r == DAL_ST_SECURE
	) else $error("Security level not taken");
	AST_SEC_MEMORY: assert property (
		@(posedge clk) disable iff (rst)
		state_r == DAL_ST_EVAL && sec_r |=> state_r == DAL_ST_SECURE
	) else $error("Security lost across reset");
	AST_FW_DISABLE: assert property (
		@(posedge clk) disable iff (rst)
		state_r == DAL_ST_OPEN && fw_dbg_disable && !sec_max
		|=> state_r == DAL_ST_CLOSED
	) else $error("Firmware disable ignored");
	AST_HOST_NO_CLOSE: assert property (
		@(posedge clk) disable iff (rst)
		state_r == DAL_ST_OPEN && !fw_dbg_disable && !sec_max
		|=> state_r == DAL_ST_OPEN
	) else $error("Debug closed without firmware");
	AST_REOPEN_GUARD: assert property (
		@(posedge clk) disable iff (rst)
		state_r == DAL_ST_CLOSED && (flash_protected || !device_erased)
		|=> state_r != DAL_ST_OPEN
	) else $error("Reopened without erase");
	AST_CLOSED_MEMORY: assert property (
		@(posedge clk) disable iff (rst)
		state_r == DAL_ST_EVAL && !en_r && !sec_r && !sec_max
		|=> state_r == DAL_ST_CLOSED
	) else $error("Disable lost across reset");
	AST_DEFAULT_OPEN: assert property (
		@(posedge clk) disable iff (rst)
		$fell(rst) && en_r && !sec_max |=> state_r == DAL_ST_OPEN
	) else $error("Debug not open after reset");
	AST_OPEN_ENABLED: assert property (
		@(posedge clk) disable iff (rst)
		state_r == DAL_ST_OPEN |-> en_r && !sec_r
	) else $error("Open without enable memory");
	AST_GRANT_SWD: assert property (
		@(posedge clk) disable iff (rst)
		swd_grant |-> req_r && dbg_enable
	) else $error("Grant without request");
	AST_COUNTS: assert property (
		@(posedge clk) disable iff (rst)
		bkpt_count == 3'h4 && wpt_count == 2'h2
	) else $error("Comparator counts wrong");

	// ==========================================================
	// Covers
	COV_OPEN: cover property (@(posedge clk) disable iff (rst) swd_grant);
	COV_CLOSE: cover property (@(posedge clk) disable iff (rst)
		state_r == DAL_ST_OPEN ##1 state_r == DAL_ST_CLOSED);
	COV_REOPEN: cover property (@(posedge clk) disable iff (rst)
		state_r == DAL_ST_CLOSED ##1 state_r == DAL_ST_OPEN);
	COV_SECURE: cover property (@(posedge clk) disable iff (rst) sec_locked);
	COV_SEC_AFTER_RST: cover property (@(posedge clk) disable iff (rst)
		state_r == DAL_ST_EVAL && sec_r ##1 sec_locked);
endmodule
`default_nettype wire

// >>> sim/dal_host_model.sv
// Host model: serial debug host raising its access request.
// Assumes the bench says when the host wants access.
`timescale 1ns/10ps
`default_nettype none
module dal_host_model (
	input wire logic clk,
	input wire logic want,
	output logic swd_req_pin
);
	initial swd_req_pin = 1'b0;
	// Only a request wire; the host cannot close debug
	always @(posedge clk) begin
		swd_req_pin <= #1 want;
	end
endmodule
`default_nettype wire

// >>> sim/dal_debug_access_lock_tb.sv
// Bench for the debug access lock: host model, firmware stimulus, checks.
// Assumes lock memory powers up with debug enabled and survives rst.
`timescale 1ns/10ps
`default_nettype none
module dal_debug_access_lock_tb;
	import dal_pkg::*;
	logic clk = 1'b0, rst = 1'b1, want = 1'b0, dis = 1'b0, en = 1'b0;
	logic prot = 1'b0, ers = 1'b0, sec = 1'b0, pin, grant, dbg, tst, lck;
	logic [2:0] bk;
	logic [1:0] wp;
	dal_state_t st;
	logic [10:0] q[$];
	int fail_count = 0, num_checks = 0, cyc = 0;
	logic [31:0] rs = 32'h9585;
	always #2 clk = ~clk;
	dal_host_model i_dal_host_model (.clk(clk), .want(want),
		.swd_req_pin(pin));
	dal_debug_access_lock i_dal_debug_access_lock (.clk(clk), .rst(rst),
		.fw_dbg_disable(dis), .fw_dbg_enable(en), .flash_protected(prot),
		.device_erased(ers), .sec_max(sec), .swd_req_pin(pin),
		.swd_grant(grant), .dbg_enable(dbg), .test_enable(tst),
		.sec_locked(lck), .bkpt_count(bk), .wpt_count(wp), .state(st));
	// ==========================================================
	// Helpers
	function automatic logic [31:0] xs(input logic [31:0] v);
		v ^= v << 13;
		v ^= v >> 17;
		v ^= v << 5;
		return v;
	endfunction
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic note(input dal_state_t s, input logic g);
		q.push_back({s, g, s == DAL_ST_OPEN, s == DAL_ST_OPEN,
			s == DAL_ST_SECURE, 3'h4, 2'h2});
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// ==========================================================
	// Monitor and timeout
	always @(negedge clk) begin
		if (q.size() != 0) begin
			num_checks++;
			if (q[0] !== {st, grant, dbg, tst, lck, bk, wp}) begin
				fail_count++;
				$display("Error at %0t: got %h want %h", $time,
					{st, grant, dbg, tst, lck, bk, wp}, q[0]);
			end
			void'(q.pop_front());
		end
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 400) begin
			fail_count++;
			results();
		end
	end
	// ==========================================================
	// Scenarios
	initial begin
		repeat (8) @(posedge clk);
		#1 rst = 1'b0;
		note(DAL_ST_EVAL, 1'b0);
		step(1);
		note(DAL_ST_OPEN, 1'b0);
		want = 1'b1;
		step(5);
		note(DAL_ST_OPEN, 1'b1);
		for (int i = 0; i < 8; i++) begin
			rs = xs(rs);
			{en, prot, ers} = rs[2:0];
			step(1);
			note(DAL_ST_OPEN, 1'b1);
		end
		{en, prot, ers} = 3'h0;
		dis = 1'b1;
		step(1);
		dis = 1'b0;
		note(DAL_ST_CLOSED, 1'b0);
		$display("test open and close done");
		step(1);
		rst = 1'b1;
		step(2);
		rst = 1'b0;
		step(1);
		note(DAL_ST_CLOSED, 1'b0);
		{en, prot, ers} = 3'h7;
		step(1);
		note(DAL_ST_CLOSED, 1'b0);
		{en, prot, ers} = 3'h4;
		step(1);
		note(DAL_ST_CLOSED, 1'b0);
		ers = 1'b1;
		step(1);
		note(DAL_ST_OPEN, 1'b1);
		en = 1'b0;
		$display("test reopen done");
		sec = 1'b1;
		step(1);
		note(DAL_ST_SECURE, 1'b0);
		sec = 1'b0;
		en = 1'b1;
		step(1);
		note(DAL_ST_SECURE, 1'b0);
		step(1);
		rst = 1'b1;
		step(2);
		rst = 1'b0;
		step(1);
		note(DAL_ST_SECURE, 1'b0);
		step(1);
		$display("test secure done");
		results();
	end
endmodule
`default_nettype wire
